// ==== hdl/counter_pkg.sv ====
// Package with register map, flag layout and carrier types of the event counter.
package counter_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int IRQ_W    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] SCAN_OFS     = 8'h00;
  localparam logic [7:0] PRESET_OFS   = 8'h04;
  localparam logic [7:0] ACC_OFS      = 8'h08;
  localparam logic [7:0] FLAGS_OFS    = 8'h0C;
  localparam logic [7:0] MODE_OFS     = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Flag positions in the status word and interrupt event positions.
  localparam int UNF_BIT     = 11;
  localparam int OVF_BIT     = 12;
  localparam int DONE_BIT    = 13;
  localparam int DOWN_EN_BIT = 14;
  localparam int UP_EN_BIT   = 15;
  localparam int EVT_OVF     = 0;
  localparam int EVT_UNF     = 1;
  localparam int EVT_DONE    = 2;
  localparam int EVT_COUNT   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and count limits.
  localparam logic signed [15:0] ACC_RESET    = 16'sh0000;
  localparam logic signed [15:0] PRESET_RESET = 16'sh0000;
  localparam logic signed [15:0] ACC_MAX      = 16'sh7FFF;
  localparam logic signed [15:0] ACC_MIN      = 16'sh8000;
  localparam logic signed [15:0] ACC_ONE      = 16'sh0001;
  localparam logic [1:0]         MODE_RESET   = 2'h0;
  localparam logic [IRQ_W-1:0]   IRQ_RESET    = 4'h0;

  // Field order matches bits 15 down to 11 of the status word.
  typedef struct packed {
    logic upEnable;
    logic downEnable;
    logic done;
    logic overflow;
    logic underflow;
  } flags_t;

  typedef struct packed {
    logic resetRung;
    logic downRung;
    logic upRung;
  } rung_t;

endpackage : counter_pkg

// ==== hdl/up_down_event_counter.sv ====
// Retentive up/down event counter element with a classic Wishbone register slave.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

// What this block does
// - A new true down rung decrements the accumulator by exactly one.
// - Accumulator holds its value until a reset operation clears it.
// - Decrement past the negative limit wraps to positive extreme, sets underflow bit 11.
// - Underflow stays set until reset or an up count reaches the positive limit.
// - Done bit 13 is set by an evaluation without reset that leaves the accumulator at or above the preset.
// - Down enable bit 14 follows the down rung; cleared by rung false or reset.
// - Accumulator and done, overflow, underflow flags survive rungs going false.
// - Entering remote run or test mode forces all count enable flags set.
// - A reset operation zeroes the accumulator and clears all five flags.
// - Reset together with an enabled count rung clears that enable flag.
// - With a negative preset, the count after a reset sets done.
// - Accumulator and preset are signed 16-bit two's complement values.
// - A new true up rung increments; wrap to negative limit sets overflow bit 12.
// - Up enable bit 15 follows the up rung; cleared by rung false or reset.
module up_down_event_counter (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           resetn,
  // Wishbone slave
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [counter_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [counter_pkg::DATA_W-1:0] dat_i,
  output logic      [counter_pkg::DATA_W-1:0] dat_o,
  output logic                                ack_o,
  // Interrupt
  output logic                                irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic signed [15:0]               acc_reg;
  logic signed [15:0]               acc_next;
  logic signed [15:0]               preset_reg;
  logic signed [15:0]               preset_next;
  counter_pkg::flags_t              flags_reg;
  counter_pkg::flags_t              flags_next;
  counter_pkg::rung_t               rung_reg;
  logic [1:0]                       mode_reg;
  logic [counter_pkg::IRQ_W-1:0]    irqStat_reg;
  logic [counter_pkg::IRQ_W-1:0]    irqStat_next;
  logic [counter_pkg::IRQ_W-1:0]    irqMask_reg;
  logic [counter_pkg::DATA_W-1:0]   dat_reg;
  logic                             ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. The answer comes one cycle after the request; writes and
  // read side effects happen at the edge where ack is high.
  wire busReq     = cyc_i & stb_i;
  wire ackPhase   = busReq & ack_reg;
  wire wrDone     = ackPhase & we_i;
  wire rdDone     = ackPhase & ~we_i;
  wire hitScan    = adr_i == counter_pkg::SCAN_OFS;
  wire hitPreset  = adr_i == counter_pkg::PRESET_OFS;
  wire hitAcc     = adr_i == counter_pkg::ACC_OFS;
  wire hitFlags   = adr_i == counter_pkg::FLAGS_OFS;
  wire hitMode    = adr_i == counter_pkg::MODE_OFS;
  wire hitIrqStat = adr_i == counter_pkg::IRQ_STAT_OFS;
  wire hitIrqMask = adr_i == counter_pkg::IRQ_MASK_OFS;

  // One write to the scan register is one evaluation of the three rungs.
  wire evalNow   = wrDone & hitScan & sel_i[0];
  wire upRungIn  = dat_i[0];
  wire dnRungIn  = dat_i[1];
  wire rstRungIn = dat_i[2];
  wire modeWr    = wrDone & hitMode & sel_i[0];
  // Only a mode bit going from clear to set is an entry into that mode.
  wire modeEntry = modeWr & (|(dat_i[1:0] & ~mode_reg));

  ////////////////////////////////////////////////////////////////////////////
  // Counting datapath.
  wire upEdge = upRungIn & ~flags_reg.upEnable;
  wire dnEdge = dnRungIn & ~flags_reg.downEnable;
  wire upWrap = upEdge & (acc_reg == counter_pkg::ACC_MAX);
  // Sums stay at 16 bits so the wrap falls out of two's complement.
  wire signed [15:0] accUp = upEdge ? acc_reg + counter_pkg::ACC_ONE : acc_reg;
  wire dnWrap = dnEdge & (accUp == counter_pkg::ACC_MIN);
  wire signed [15:0] accDn = dnEdge ? accUp - counter_pkg::ACC_ONE : accUp;

  always_comb begin
    acc_next   = acc_reg;
    flags_next = flags_reg;
    if (evalNow) begin
      if (rstRungIn) begin
        // Reset wins over any count in the same evaluation.
        acc_next   = counter_pkg::ACC_RESET;
        flags_next = '0;
      end else begin
        acc_next              = accDn;
        flags_next.upEnable   = upRungIn;
        flags_next.downEnable = dnRungIn;
        flags_next.done       = accDn >= preset_reg;
        if (upWrap) begin
          flags_next.overflow = 1'b1;
        end else if (dnEdge) begin
          flags_next.overflow = 1'b0;
        end
        if (dnWrap) begin
          flags_next.underflow = 1'b1;
        end else if (upEdge && accUp == counter_pkg::ACC_MAX) begin
          flags_next.underflow = 1'b0;
        end
      end
    end
    if (modeEntry) begin
      flags_next.upEnable   = 1'b1;
      flags_next.downEnable = 1'b1;
    end
  end

  assign preset_next = (wrDone & hitPreset) ?
                       {sel_i[1] ? dat_i[15:8] : preset_reg[15:8], sel_i[0] ? dat_i[7:0] : preset_reg[7:0]} :
                       preset_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status. A read clears only the bits it returned, so an event
  // landing between capture and ack is never lost; a set beats a clear.
  wire [counter_pkg::IRQ_W-1:0] irqEvt = {
    evalNow & (upEdge | dnEdge) & ~rstRungIn,
    ~flags_reg.done & flags_next.done,
    ~flags_reg.underflow & flags_next.underflow,
    ~flags_reg.overflow & flags_next.overflow
  };
  wire [counter_pkg::IRQ_W-1:0] irqClr = (rdDone & hitIrqStat) ? dat_reg[counter_pkg::IRQ_W-1:0] : '0;
  assign irqStat_next = (irqStat_reg & ~irqClr) | irqEvt;
  assign irq          = |(irqStat_reg & irqMask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero and are still acknowledged.
  wire [counter_pkg::DATA_W-1:0] rdData =
    hitScan    ? {29'h0, rung_reg} :
    hitPreset  ? {16'h0, preset_reg} :
    hitAcc     ? {16'h0, acc_reg} :
    hitFlags   ? {16'h0, flags_reg, 11'h0} :
    hitMode    ? {30'h0, mode_reg} :
    hitIrqStat ? {28'h0, irqStat_reg} :
    hitIrqMask ? {28'h0, irqMask_reg} : 32'h0000_0000;

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= busReq & ~ack_reg;
      if (busReq & ~ack_reg) begin
        dat_reg <= rdData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc_reg     <= counter_pkg::ACC_RESET;
      flags_reg   <= '0;
      preset_reg  <= counter_pkg::PRESET_RESET;
      irqStat_reg <= counter_pkg::IRQ_RESET;
    end else begin
      acc_reg     <= acc_next;
      flags_reg   <= flags_next;
      preset_reg  <= preset_next;
      irqStat_reg <= irqStat_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rung_reg    <= '0;
      mode_reg    <= counter_pkg::MODE_RESET;
      irqMask_reg <= counter_pkg::IRQ_RESET;
    end else begin
      if (evalNow) begin
        rung_reg <= dat_i[2:0];
      end
      if (modeWr) begin
        mode_reg <= dat_i[1:0];
      end
      if (wrDone & hitIrqMask & sel_i[0]) begin
        irqMask_reg <= dat_i[counter_pkg::IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence evalDown;
    evalNow && !rstRungIn && dnEdge && !upEdge;
  endsequence

  sequence evalUp;
    evalNow && !rstRungIn && upEdge && !dnEdge;
  endsequence

  down_step_a: assert property (evalDown and (acc_reg != counter_pkg::ACC_MIN)
      |=> acc_reg == $past(acc_reg) - counter_pkg::ACC_ONE)
    else $error("down count did not subtract one");

  acc_hold_a: assert property (!evalNow |=> $stable(acc_reg))
    else $error("accumulator moved without an evaluation");

  under_wrap_a: assert property (evalDown and (acc_reg == counter_pkg::ACC_MIN)
      |=> acc_reg == counter_pkg::ACC_MAX && flags_reg.underflow)
    else $error("underflow wrap wrong");

  unf_keep_a: assert property (flags_reg.underflow && !evalNow |=> flags_reg.underflow)
    else $error("underflow dropped without cause");

  done_track_a: assert property (evalNow && !rstRungIn
      |=> flags_reg.done == (acc_reg >= preset_reg))
    else $error("done flag disagrees with preset compare");

  down_en_a: assert property (evalNow
      |=> flags_reg.downEnable == ($past(dnRungIn) && !$past(rstRungIn)))
    else $error("down enable flag wrong");

  mode_force_a: assert property (modeEntry |=> flags_reg.downEnable && flags_reg.upEnable)
    else $error("mode entry did not set enable flags");

  reset_clear_a: assert property (evalNow && rstRungIn
      |=> acc_reg == counter_pkg::ACC_RESET && flags_reg == '0)
    else $error("reset operation did not clear element");

  over_wrap_a: assert property (evalUp and (acc_reg == counter_pkg::ACC_MAX)
      |=> acc_reg == counter_pkg::ACC_MIN && flags_reg.overflow)
    else $error("overflow wrap wrong");

  no_retrigger_a: assert property (evalNow && flags_reg.upEnable && flags_reg.downEnable && !rstRungIn
      |=> $stable(acc_reg))
    else $error("count without a rising rung");

  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on the counting steps, the retained state and the bus.
  sequence evalReset;
    evalNow && rstRungIn;
  endsequence

  sequence evalBoth;
    evalNow && !rstRungIn && upEdge && dnEdge;
  endsequence

  sequence evalIdle;
    evalNow && !rstRungIn && !upEdge && !dnEdge;
  endsequence

  sequence busStart;
    busReq && !ack_reg;
  endsequence

  up_step_a: assert property (evalUp and (acc_reg != counter_pkg::ACC_MAX)
      |=> acc_reg == $past(acc_reg) + counter_pkg::ACC_ONE)
    else $error("up count did not add one");

  unf_clear_a: assert property (evalUp and (acc_reg == counter_pkg::ACC_MAX - counter_pkg::ACC_ONE)
      |=> !flags_reg.underflow)
    else $error("underflow kept after reaching the positive limit");

  up_en_a: assert property (evalNow
      |=> flags_reg.upEnable == ($past(upRungIn) && !$past(rstRungIn)))
    else $error("up enable flag wrong");

  down_en_set_a: assert property (evalDown
      |=> flags_reg.downEnable)
    else $error("down enable flag not set by a true rung");

  reset_wins_a: assert property (evalReset and (upRungIn || dnRungIn)
      |=> !flags_reg.upEnable && !flags_reg.downEnable)
    else $error("reset with an enabled rung left an enable flag set");

  both_net_a: assert property (evalBoth
      |=> $stable(acc_reg))
    else $error("up and down edges together did not cancel");

  idle_eval_a: assert property (evalIdle
      |=> $stable(acc_reg))
    else $error("accumulator moved on an evaluation without an edge");

  flag_keep_a: assert property (!evalNow
      |=> $stable(flags_reg.done) && $stable(flags_reg.overflow) && $stable(flags_reg.underflow))
    else $error("retained flag changed without an evaluation");

  ovf_keep_a: assert property (flags_reg.overflow && !evalNow
      |=> flags_reg.overflow)
    else $error("overflow dropped without cause");

  ovf_clear_a: assert property (evalDown
      |=> !flags_reg.overflow)
    else $error("overflow kept after a down count");

  en_hold_a: assert property (!evalNow && !modeEntry
      |=> $stable(flags_reg.downEnable) && $stable(flags_reg.upEnable))
    else $error("enable flag changed without an evaluation");

  done_neg_a: assert property (evalIdle and (acc_reg == counter_pkg::ACC_RESET) and (preset_reg < acc_reg)
      |=> flags_reg.done)
    else $error("zero accumulator above a negative preset did not set done");

  done_low_a: assert property (evalIdle and (acc_reg < preset_reg)
      |=> !flags_reg.done)
    else $error("done set below the preset");

  preset_hold_a: assert property (!(wrDone && hitPreset)
      |=> $stable(preset_reg))
    else $error("preset changed without a write");

  scan_hold_a: assert property (!evalNow
      |=> $stable(rung_reg))
    else $error("stored rung bits changed without an evaluation");

  irq_done_a: assert property (irqEvt[counter_pkg::EVT_DONE]
      |=> irqStat_reg[counter_pkg::EVT_DONE])
    else $error("done event did not reach the status bit");

  irq_count_a: assert property (evalDown
      |=> irqStat_reg[counter_pkg::EVT_COUNT])
    else $error("down count did not raise the count event");

  ack_answer_a: assert property (busStart
      |=> ack_o)
    else $error("request not answered in the next cycle");

  // The slave answers in exactly one cycle, so a master that keeps the request up sees a second ack two cycles after the first.
  ack_idle_a: assert property (!busReq
      |=> !ack_o)
    else $error("ack raised without a request");

endmodule : up_down_event_counter

// ==== testbench/scan_master.sv ====
// Program scan partner: a classic Wishbone master that hands rung conditions to the counter.
`timescale 1ns/1ps
module scan_master (
  // Clock
  input  wire logic                           ref_clk,
  // Wishbone master side
  output logic                                cyc,
  output logic                                stb,
  output logic                                we,
  output logic      [counter_pkg::ADDR_W-1:0] adr,
  output logic      [3:0]                     sel,
  output logic      [counter_pkg::DATA_W-1:0] dat,
  input  wire logic [counter_pkg::DATA_W-1:0] datIn,
  input  wire logic                           ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end

  // One SCAN write is one evaluation, so the rung is always evaluated between transitions.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    q = datIn;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    // A released data bus must not keep showing the last value.
    dat <= ~d;
  endtask : xfer
endmodule : scan_master

// ==== testbench/up_down_event_counter_bench.sv ====
// Self-checking bench for the up/down event counter driven through its register bus.
`timescale 1ns/1ps
module up_down_event_counter_bench;
  logic        ref_clk;
  logic        resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW;
  logic [31:0] datR;
  logic        ack;
  logic        irq;
  logic [31:0] q;
  int          n_mismatch;
  int          compares;
  int          cycles;
  // Rows: scan bits, expected accumulator, expected flag word, with preset 2.
  logic [2:0]  rowScan [9] = '{3'h1, 3'h1, 3'h0, 3'h1, 3'h2, 3'h0, 3'h3, 3'h4, 3'h5};
  logic [15:0] rowAcc  [9] = '{16'h0001, 16'h0001, 16'h0001, 16'h0002, 16'h0001, 16'h0001, 16'h0001,
                               16'h0000, 16'h0000};
  logic [15:0] rowFlg  [9] = '{16'h8000, 16'h8000, 16'h0000, 16'hA000, 16'h4000, 16'h0000, 16'hC000,
                               16'h0000, 16'h0000};

  up_down_event_counter u_dut (.ref_clk(ref_clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .irq(irq));
  scan_master u_scan (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(datW),
    .datIn(datR), .ack(ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_scan.xfer(1'b1, a, 4'h3, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    u_scan.xfer(1'b0, a, 4'h3, 32'h0000_0000, q);
  endtask : rd

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Each access takes three cycles, so this ceiling leaves a wide margin.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // Wrapping past either limit needs over 32768 evaluations at several cycles each, which does
  // not fit the run length; those flags are guarded by the design's own assertions.
  initial begin
    resetn = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(counter_pkg::ACC_OFS);
    check(q, 32'h0000_0000);
    rd(counter_pkg::FLAGS_OFS);
    check(q, 32'h0000_0000);
    rd(8'h1C);
    check(q, 32'h0000_0000);
    wr(counter_pkg::PRESET_OFS, 32'h0000_0002);
    rd(counter_pkg::PRESET_OFS);
    check(q, 32'h0000_0002);
    for (int i = 0; i < 9; i++) begin
      wr(counter_pkg::SCAN_OFS, {29'h0, rowScan[i]});
      rd(counter_pkg::ACC_OFS);
      check(q, {16'h0, rowAcc[i]});
      rd(counter_pkg::FLAGS_OFS);
      check(q, {16'h0, rowFlg[i]});
    end
    check({31'h0, irq}, 32'h0000_0000);
    rd(counter_pkg::IRQ_STAT_OFS);
    check(q, 32'h0000_000C);
    rd(counter_pkg::IRQ_STAT_OFS);
    check(q, 32'h0000_0000);
    // Mode entry forces both enables, so a true down rung right after it does not count.
    wr(counter_pkg::MODE_OFS, 32'h0000_0001);
    rd(counter_pkg::FLAGS_OFS);
    check(q, 32'h0000_C000);
    wr(counter_pkg::SCAN_OFS, 32'h0000_0002);
    rd(counter_pkg::ACC_OFS);
    check(q, 32'h0000_0000);
    wr(counter_pkg::MODE_OFS, 32'h0000_0003);
    rd(counter_pkg::FLAGS_OFS);
    check(q, 32'h0000_C000);
    rd(counter_pkg::MODE_OFS);
    check(q, 32'h0000_0003);
    rd(counter_pkg::SCAN_OFS);
    check(q, 32'h0000_0002);
    // Negative preset: reset then the next evaluation raises done and the masked interrupt.
    wr(counter_pkg::IRQ_MASK_OFS, 32'h0000_0004);
    wr(counter_pkg::PRESET_OFS, 32'h0000_FFFD);
    wr(counter_pkg::SCAN_OFS, 32'h0000_0006);
    rd(counter_pkg::FLAGS_OFS);
    check(q, 32'h0000_0000);
    rd(counter_pkg::IRQ_STAT_OFS);
    check(q, 32'h0000_0000);
    wr(counter_pkg::SCAN_OFS, 32'h0000_0000);
    rd(counter_pkg::FLAGS_OFS);
    check(q, 32'h0000_2000);
    check({31'h0, irq}, 32'h0000_0001);
    rd(counter_pkg::IRQ_STAT_OFS);
    check(q, 32'h0000_0004);
    @(posedge ref_clk);
    check({31'h0, irq}, 32'h0000_0000);
    wrap_up();
  end
endmodule : up_down_event_counter_bench
